// ---- rtl/mcuic_pkg.sv ----
// constants for the microcontroller interrupt control block
package mcuic_pkg;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // register indices on the plain register port
  localparam logic [1:0] REG_CTRL_A   = 2'h0;
  localparam logic [1:0] REG_CTRL_B   = 2'h1;
  localparam logic [1:0] REG_CMP_SEL  = 2'h2;
  localparam logic [1:0] REG_IRQ_STAT = 2'h3;

  // irq_ctrl_a fields
  localparam int unsigned A_MASTER_EN = 0;
  localparam int unsigned A_PIN_EN    = 1;
  localparam int unsigned A_T0_EN     = 2;
  localparam int unsigned A_T1_EN     = 3;
  localparam int unsigned A_PIN_FLAG  = 4;
  localparam int unsigned A_T0_FLAG   = 5;
  localparam int unsigned A_T1_FLAG   = 6;
  // irq_ctrl_b fields
  localparam int unsigned B_CONV_EN   = 0;
  localparam int unsigned B_TB_EN     = 1;
  localparam int unsigned B_COMB_EN   = 2;
  localparam int unsigned B_CONV_FLAG = 4;
  localparam int unsigned B_TB_FLAG   = 5;
  localparam int unsigned B_COMB_FLAG = 6;

  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_MASK_SMALL = 8'h37;
  localparam logic [7:0] CTRL_A_MASK_LARGE = 8'h7F;
  localparam logic [7:0] CTRL_B_MASK       = 8'h77;

  // comparator edge selection
  localparam logic [1:0] CMP_FALL = 2'h0;
  localparam logic [1:0] CMP_RISE = 2'h1;
  localparam logic [1:0] CMP_BOTH = 2'h2;

  // source order, highest priority first
  localparam int unsigned NSRC     = 6;
  localparam int unsigned SRC_PIN  = 0;
  localparam int unsigned SRC_T0   = 1;
  localparam int unsigned SRC_T1   = 2;
  localparam int unsigned SRC_CONV = 3;
  localparam int unsigned SRC_TB   = 4;
  localparam int unsigned SRC_COMB = 5;

  localparam logic [7:0] VEC_PIN  = 8'h04;
  localparam logic [7:0] VEC_T0   = 8'h08;
  localparam logic [7:0] VEC_T1   = 8'h0C;
  localparam logic [7:0] VEC_CONV = 8'h10;
  localparam logic [7:0] VEC_TB   = 8'h14;
  localparam logic [7:0] VEC_COMB = 8'h18;

  localparam logic [1:0] LAT_NORMAL = 2'h2;
  localparam logic [1:0] LAT_WAKE   = 2'h3;

  typedef enum logic [1:0] {
    MCUIC_IDLE,
    MCUIC_WAIT,
    MCUIC_TAKE
  } mcuic_state_t;
endpackage

// ---- rtl/mcuic_top.sv ----
// interrupt flags, enables, priority and vectoring for the core sequencer
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// RULE1: comparator edge select: 00 falling, 01 rising, 10 both, 11 unused.
// RULE2: unused register bits read back as zero.
// RULE3: an event sets its flag regardless of enable state.
// RULE4: every source has its own software enable bit.
// RULE5: master enable in control A bit 0 gates all interrupts.
// RULE6: pin source: flag control A bit 4, enable bit 1.
// RULE7: timer zero: flag control A bit 5, enable bit 2.
// RULE8: timer one: flag bit 6, enable bit 3; zero on small variant.
// RULE9: time base: flag control B bit 5, enable bit 1.
// RULE10: conversion done: flag control B bit 4, enable bit 0.
// RULE11: an accepted interrupt diverts the program to its handler.
// RULE12: combined source flag B bit 6, enable bit 2; all reset zero.
// RULE13: take a source only with flag, enable and master enable set.
// RULE14: taking an interrupt clears master enable; new flags still set.
// RULE15: fixed priority, pin highest at 04H, combined lowest at 18H.
// RULE16: no acknowledge while the return stack is full.
// RULE17: request to vector jump takes 2 cycles, 3 after wake-up.
module mcuic_top
  import mcuic_pkg::*;
#(
  parameter bit HAS_TIMER_ONE = 1'b1
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic [mcuic_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [mcuic_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [mcuic_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       pin_event,
  input  wire logic                       timer_zero_event,
  input  wire logic                       timer_one_event,
  input  wire logic                       conversion_done_event,
  input  wire logic                       timebase_event,
  input  wire logic                       comb_src_event,
  input  wire logic                       comparator_out,
  input  wire logic                       instr_cycle,
  input  wire logic                       woke_up,
  input  wire logic                       stack_full,
  input  wire logic                       irq_ack,
  output logic                            irq_take,
  output logic      [7:0]                 irq_vector,
  output logic                            irq_out
);
  import mcuic_pkg::*;

  localparam logic [7:0] A_MASK =
    HAS_TIMER_ONE ? CTRL_A_MASK_LARGE : CTRL_A_MASK_SMALL;

  logic [7:0]        ctrl_a_q;
  logic [7:0]        ctrl_b_q;
  logic [1:0]        cmp_sel_q;
  logic              cmp_prev_q;
  logic              cmp_init_q;
  logic [NSRC-1:0]   src_flag;
  logic [NSRC-1:0]   src_en;
  logic [NSRC-1:0]   src_ready;
  logic [NSRC-1:0]   take_onehot;
  logic              cmp_hit;
  logic              master_irq_enable;
  logic [7:0]        vec_d;
  logic [7:0]        vec_q;
  logic [1:0]        lat_q;
  logic              wake_q;
  mcuic_state_t      state_q;
  logic              any_ready;

  // next values of the registers above
  mcuic_state_t      state_d;
  logic [7:0]        ctrl_a_d;
  logic [7:0]        ctrl_b_d;
  logic [7:0]        rdata_d;

  // comparator edges before the select is applied
  logic              cmp_rise;
  logic              cmp_fall;

  // latency counter end points and the value shown before any take
  localparam logic [1:0] LAT_NONE = 2'h0;
  localparam logic [1:0] LAT_LAST = 2'h1;
  localparam logic [7:0] VEC_NONE = 8'h00;

  assign master_irq_enable = ctrl_a_q[A_MASTER_EN]; // RULE5

  // first sample after reset has no history, so no edge is reported then
  assign cmp_rise = ~cmp_prev_q & comparator_out;
  assign cmp_fall = cmp_prev_q & ~comparator_out;

  // comparator edge detection feeding the combined source
  always_comb begin
    case (cmp_sel_q)
      CMP_FALL: cmp_hit = cmp_fall; // RULE1
      CMP_RISE: cmp_hit = cmp_rise; // RULE1
      CMP_BOTH: cmp_hit = cmp_rise | cmp_fall; // RULE1
      default:  cmp_hit = 1'b0;
    endcase
    cmp_hit = cmp_hit & cmp_init_q;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_prev_q <= 1'b0;
      cmp_init_q <= 1'b0;
    end else begin
      cmp_prev_q <= comparator_out;
      cmp_init_q <= 1'b1;
    end
  end

  // gather flags and enables in priority order
  always_comb begin
    src_flag = '0;
    src_en   = '0;
    src_flag[SRC_PIN]  = ctrl_a_q[A_PIN_FLAG]; // RULE6
    src_en[SRC_PIN]    = ctrl_a_q[A_PIN_EN]; // RULE6
    src_flag[SRC_T0]   = ctrl_a_q[A_T0_FLAG]; // RULE7
    src_en[SRC_T0]     = ctrl_a_q[A_T0_EN]; // RULE7
    src_flag[SRC_T1]   = ctrl_a_q[A_T1_FLAG]; // RULE8
    src_en[SRC_T1]     = ctrl_a_q[A_T1_EN]; // RULE8
    src_flag[SRC_CONV] = ctrl_b_q[B_CONV_FLAG]; // RULE10
    src_en[SRC_CONV]   = ctrl_b_q[B_CONV_EN]; // RULE10
    src_flag[SRC_TB]   = ctrl_b_q[B_TB_FLAG]; // RULE9
    src_en[SRC_TB]     = ctrl_b_q[B_TB_EN]; // RULE9
    src_flag[SRC_COMB] = ctrl_b_q[B_COMB_FLAG]; // RULE12
    src_en[SRC_COMB]   = ctrl_b_q[B_COMB_EN]; // RULE12
  end

  assign src_ready = src_flag & src_en & {NSRC{master_irq_enable}}; // RULE13
  assign any_ready = |src_ready;
  // lowest index wins
  assign take_onehot = src_ready & (~src_ready + 1'b1); // RULE15

  always_comb begin
    vec_d = VEC_COMB;
    case (1'b1)
      take_onehot[SRC_PIN]:  vec_d = VEC_PIN; // RULE15
      take_onehot[SRC_T0]:   vec_d = VEC_T0;
      take_onehot[SRC_T1]:   vec_d = VEC_T1;
      take_onehot[SRC_CONV]: vec_d = VEC_CONV;
      take_onehot[SRC_TB]:   vec_d = VEC_TB;
      default:               vec_d = VEC_COMB; // RULE15
    endcase
  end

  // sequence: wait the instruction-cycle latency, then hand the vector over
  // stack_full only blocks a new take; one already handed over waits for ack
  logic take_now;
  assign take_now = (state_q == MCUIC_WAIT) && instr_cycle &&
                    (lat_q == LAT_LAST) && any_ready && !stack_full; // RULE16

  // next state; a request that vanishes while waiting abandons the take
  always_comb begin
    state_d = state_q;
    case (state_q)
      MCUIC_IDLE: begin
        if (any_ready && !stack_full) begin // RULE16
          state_d = MCUIC_WAIT;
        end
      end
      MCUIC_WAIT: begin
        if (!any_ready) begin
          state_d = MCUIC_IDLE;
        end else if (take_now) begin
          state_d = MCUIC_TAKE; // RULE11
        end
      end
      MCUIC_TAKE: begin
        // hold the request until the sequencer has pushed the return address
        if (irq_ack) begin
          state_d = MCUIC_IDLE;
        end
      end
      default: state_d = MCUIC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= MCUIC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // a wake-up is kept until the next take so the longer latency applies
  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_q <= 1'b0;
    end else if (take_now) begin
      wake_q <= 1'b0;
    end else if (woke_up) begin
      wake_q <= 1'b1;
    end
  end

  // latency counts instruction cycles, not clocks
  // a request that drops while waiting restarts the count from the top
  always_ff @(posedge mclk) begin
    if (reset) begin
      lat_q <= LAT_NONE;
    end else if (state_q == MCUIC_IDLE && any_ready && !stack_full) begin
      lat_q <= (wake_q || woke_up) ? LAT_WAKE : LAT_NORMAL; // RULE17
    end else if (state_q == MCUIC_WAIT && any_ready && instr_cycle &&
                 lat_q != LAT_LAST) begin
      lat_q <= lat_q - LAT_LAST; // RULE17
    end
  end

  // vector and take are held until the sequencer acknowledges
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_take   <= 1'b0;
      irq_vector <= VEC_NONE;
    end else if (take_now) begin
      irq_take   <= 1'b1; // RULE11
      irq_vector <= vec_d; // RULE15
    end else if (state_q == MCUIC_TAKE && irq_ack) begin
      irq_take   <= 1'b0;
    end
  end

  // last taken vector, readable by software
  always_ff @(posedge mclk) begin
    if (reset) begin
      vec_q <= VEC_NONE;
    end else if (take_now) begin
      vec_q <= vec_d;
    end
  end

  // control A: event sets win over software writes and take clears
  always_comb begin
    ctrl_a_d = ctrl_a_q;
    if (reg_wr && reg_addr == REG_CTRL_A) begin
      ctrl_a_d = reg_wdata & A_MASK; // RULE4
    end
    if (take_now) begin
      ctrl_a_d[A_MASTER_EN] = 1'b0; // RULE14
      ctrl_a_d[A_PIN_FLAG]  = ctrl_a_d[A_PIN_FLAG] & ~take_onehot[SRC_PIN];
      ctrl_a_d[A_T0_FLAG]   = ctrl_a_d[A_T0_FLAG] & ~take_onehot[SRC_T0];
      ctrl_a_d[A_T1_FLAG]   = ctrl_a_d[A_T1_FLAG] & ~take_onehot[SRC_T1];
    end
    if (pin_event) begin
      ctrl_a_d[A_PIN_FLAG] = 1'b1; // RULE3
    end
    if (timer_zero_event) begin
      ctrl_a_d[A_T0_FLAG] = 1'b1; // RULE3
    end
    if (timer_one_event && HAS_TIMER_ONE) begin
      ctrl_a_d[A_T1_FLAG] = 1'b1; // RULE8
    end
    ctrl_a_d = ctrl_a_d & A_MASK; // RULE2
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_a_q <= CTRL_A_RESET; // RULE12
    end else begin
      ctrl_a_q <= ctrl_a_d;
    end
  end

  // control B: same ordering as control A
  always_comb begin
    ctrl_b_d = ctrl_b_q;
    if (reg_wr && reg_addr == REG_CTRL_B) begin
      ctrl_b_d = reg_wdata & CTRL_B_MASK; // RULE4
    end
    if (take_now) begin
      ctrl_b_d[B_CONV_FLAG] = ctrl_b_d[B_CONV_FLAG] & ~take_onehot[SRC_CONV];
      ctrl_b_d[B_TB_FLAG]   = ctrl_b_d[B_TB_FLAG] & ~take_onehot[SRC_TB];
      ctrl_b_d[B_COMB_FLAG] = ctrl_b_d[B_COMB_FLAG] & ~take_onehot[SRC_COMB];
    end
    if (conversion_done_event) begin
      ctrl_b_d[B_CONV_FLAG] = 1'b1; // RULE3
    end
    if (timebase_event) begin
      ctrl_b_d[B_TB_FLAG] = 1'b1; // RULE3
    end
    if (comb_src_event || cmp_hit) begin
      ctrl_b_d[B_COMB_FLAG] = 1'b1; // RULE3
    end
    ctrl_b_d = ctrl_b_d & CTRL_B_MASK; // RULE2
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_b_q <= CTRL_B_RESET; // RULE12
    end else begin
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // edge select 11 is reserved; it simply raises no comparator events
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_sel_q <= CMP_FALL;
    end else if (reg_wr && reg_addr == REG_CMP_SEL) begin
      cmp_sel_q <= reg_wdata[1:0]; // RULE1
    end
  end

  // level output: some source is pending and allowed
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= any_ready; // RULE13
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL_A:   rdata_d = ctrl_a_q & A_MASK; // RULE2
        REG_CTRL_B:   rdata_d = ctrl_b_q & CTRL_B_MASK; // RULE2
        REG_CMP_SEL:  rdata_d = {6'h00, cmp_sel_q}; // RULE2
        REG_IRQ_STAT: rdata_d = vec_q;
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end
endmodule

// ---- verification/mcuic_core_model.sv ----
// core sequencer stand-in: instruction cycle marks and take acknowledge
`timescale 1ns/1ps
module mcuic_core_model (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic irq_take,
  output logic      instr_cycle,
  output logic      irq_ack
);
  logic [1:0] phase_q;
  // four clocks per instruction cycle, like a slow core
  always_ff @(posedge mclk) begin
    if (reset) begin
      phase_q <= 2'h0;
      irq_ack <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      // late one-cycle ack so the held take is exercised
      irq_ack <= irq_take && !irq_ack && phase_q == 2'h3;
    end
  end
  assign instr_cycle = phase_q == 2'h0 && !reset;
endmodule

// ---- verification/mcuic_top_asserts.sv ----
// port checks for the interrupt control block
`timescale 1ns/1ps
module mcuic_top_asserts
  import mcuic_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       stack_full,
  input wire logic       irq_ack,
  input wire logic       irq_take,
  input wire logic [7:0] irq_vector,
  input wire logic       irq_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic mst_q;
  // shadow of master enable; lags the take by a cycle, which only relaxes
  always_ff @(posedge mclk) begin
    if (reset || irq_take) begin
      mst_q <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CTRL_A) begin
      mst_q <= reg_wdata[0];
    end
  end
  property p_top; reg_rd |=> !reg_rdata[7]; endproperty
  a_top: assert property (p_top) else $error("bit 7 read set");
  property p_b3; reg_rd && reg_addr == REG_CTRL_B |=> !reg_rdata[3]; endproperty
  a_b3: assert property (p_b3) else $error("bit 3 read set");
  property p_mst; $rose(irq_take) |-> $past(mst_q); endproperty
  a_mst: assert property (p_mst) else $error("take without master");
  property p_out; irq_out |-> $past(mst_q); endproperty
  a_out: assert property (p_out) else $error("irq_out without master");
  property p_clr; $rose(irq_take) |-> ##[1:2] !irq_out; endproperty
  a_clr: assert property (p_clr) else $error("master not cleared");
  property p_stk; stack_full |=> !$rose(irq_take); endproperty
  a_stk: assert property (p_stk) else $error("take on full stack");
  property p_hold; irq_take && !irq_ack |=> irq_take && $stable(irq_vector);
  endproperty
  a_hold: assert property (p_hold) else $error("take dropped");
  property p_lat; $rose(irq_out) && !stack_full |-> ##[2:24] irq_take;
  endproperty
  a_lat: assert property (p_lat) else $error("take too late");
endmodule
bind mcuic_top mcuic_top_asserts mcuic_top_asserts_i (.mclk(mclk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .stack_full(stack_full), .irq_ack(irq_ack), .irq_take(irq_take),
  .irq_vector(irq_vector), .irq_out(irq_out));

// ---- verification/mcuic_top_bench.sv ----
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
module mcuic_top_bench;
  import mcuic_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cmp = 1'b0, stk = 1'b0, instr_cycle, irq_ack, irq_take, irq_out;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, irq_vector;
  logic [6:0] ev = 7'h00;
  int fail_count = 0, n_checks = 0, s;
  always #2.5 mclk = ~mclk;
  mcuic_top mcuic_top_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_event(ev[0]), .timer_zero_event(ev[1]),
    .timer_one_event(ev[2]), .conversion_done_event(ev[3]),
    .timebase_event(ev[4]), .comb_src_event(ev[5]), .comparator_out(cmp),
    .instr_cycle(instr_cycle), .woke_up(ev[6]), .stack_full(stk),
    .irq_ack(irq_ack), .irq_take(irq_take), .irq_vector(irq_vector),
    .irq_out(irq_out));
  mcuic_core_model mcuic_core_model_i (.mclk(mclk), .reset(reset),
    .irq_take(irq_take), .instr_cycle(instr_cycle), .irq_ack(irq_ack));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 7'h00;
  endtask
  task automatic take(input logic [7:0] vec);
    int i;
    for (i = 0; i < 40 && irq_take !== 1'b1; i++) @(negedge mclk);
    chk({7'h00, irq_take}, 8'h01);
    chk(irq_vector, vec);
    repeat (8) @(posedge mclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd(REG_CTRL_A, CTRL_A_RESET);
    rd(REG_CTRL_B, CTRL_B_RESET);
    wr(REG_CTRL_A, 8'hFE);
    rd(REG_CTRL_A, 8'h7E);
    repeat (20) @(posedge mclk);
    chk({6'h00, irq_take, irq_out}, 8'h00);
    wr(REG_CTRL_A, 8'h00);
    wr(REG_CTRL_B, 8'hFF);
    rd(REG_CTRL_B, CTRL_B_MASK);
    wr(REG_CTRL_B, 8'h00);
    pulse(7'h3F);
    rd(REG_CTRL_A, 8'h70);
    rd(REG_CTRL_B, 8'h70);
    for (s = 0; s < 4; s++) begin
      wr(REG_CMP_SEL, {6'h00, s[1:0]});
      wr(REG_CTRL_B, 8'h00);
      cmp <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(REG_CTRL_B, {1'b0, s == 1 || s == 2, 6'h00});
      wr(REG_CTRL_B, 8'h00);
      cmp <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(REG_CTRL_B, {1'b0, s == 0 || s == 2, 6'h00});
    end
    wr(REG_CTRL_A, 8'h07);
    pulse(7'h03);
    take(VEC_PIN);
    rd(REG_CTRL_A, 8'h26);
    rd(REG_IRQ_STAT, VEC_PIN);
    pulse(7'h40);
    wr(REG_CTRL_A, 8'h27);
    take(VEC_T0);
    rd(REG_CTRL_A, 8'h06);
    wr(REG_CTRL_B, 8'h07);
    wr(REG_CTRL_A, 8'h0F);
    pulse(7'h1C);
    take(VEC_T1);
    rd(REG_CTRL_A, 8'h0E);
    wr(REG_CTRL_A, 8'h01);
    take(VEC_CONV);
    rd(REG_CTRL_B, 8'h27);
    wr(REG_CTRL_A, 8'h01);
    take(VEC_TB);
    rd(REG_CTRL_B, 8'h07);
    @(posedge mclk);
    stk <= 1'b1;
    wr(REG_CTRL_B, 8'h04);
    wr(REG_CTRL_A, 8'h01);
    pulse(7'h20);
    repeat (30) @(negedge mclk);
    chk({6'h00, irq_take, irq_out}, 8'h01);
    @(posedge mclk);
    stk <= 1'b0;
    take(VEC_COMB);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
endmodule
